/* File: hw/nvc_command_controller.sv */
// Purpose: Register front end of the nonvolatile memory command controller
// Assumes: Avalon-MM slave, byte data in low bits, one wait state on every access
// Notes: Array operations are modelled by a timer; strobes to the arrays are pulses
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - Codes 0, 4, 6: none, buffer clear, EEPROM wipe
// - Codes 1-3 write, erase, erase-write page
// - Code 5 full erase; keep fuse spares EEPROM
// - Fuse program only from debug port
// - Boot lock makes boot reads return zero
// - Boot lock set from boot only, reset clears
// - Boot lock effective after first boot exit
// - App write protect set-only, blocks app writes
// - Write fault on mixed sections or protection
// - Busy flags while flash or EEPROM operate
// - Ready interrupt enable, level request
// - Ready flag set while idle, write one clears
// - Data word at 0x06, only read back
// - Address word at 0x08, set only by bus writes; picks EEPROM and protected range
// - Page buffer cleared after page write or erase, and after buffer clear
// - Unlocked-less command write leaves register unchanged
// - Interrupt while enabled and flag set
module nvc_command_controller
  import nvc_pkg::*;
#(
  parameter logic [15:0] EEPROM_BASE = 16'h1400,
  parameter logic [15:0] EEPROM_END = 16'h14FF,
  parameter logic [15:0] BOOT_END = 16'h01FF,
  parameter logic [15:0] APP_END = 16'h7FFF
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic dbgPortAccess,
  input wire logic cpuInBoot,
  input wire logic eepromKeepFuse,
  input wire logic pbufMixedSections,
  input wire logic [15:0] fetchAddr,
  input wire logic [15:0] fetchRawData,
  output logic [15:0] fetchData,
  output logic flashBusy,
  output logic eepromBusy,
  output logic arrayStartPulse,
  output logic [2:0] arrayCmd,
  output logic arrayKeepEeprom,
  output logic pbufClearPulse,
  output logic irqReq
);
  logic [2:0] cmd_q;
  logic appProt_q;
  logic boot_read_lock_q;
  logic lockArmed_q;
  logic wasInBoot_q;
  logic writeFault_q;
  logic irqEn_q;
  logic eeprom_ready_q;
  logic [15:0] data_q;
  logic [15:0] addr_q;
  logic [2:0] keyCnt_q;
  logic eeOp_q;
  nvc_state_e state_q;
  logic ack_q;
  logic [31:0] rdata_d;
  logic regHit;
  logic accessPend;
  logic wrStb;
  logic [3:0] idx;
  logic [7:0] wb;
  logic cmdAccept;
  logic cmdFault;
  logic cmdIsEe;
  logic busyNow;
  logic timerLoad;
  logic [7:0] timerCount;
  logic timerRunning;
  logic timerDone;
  logic bootSync1_q;
  logic bootSync2_q;
  logic keepSync1_q;
  logic keepSync2_q;
  logic dbgSync1_q;
  logic dbgSync2_q;

  // Boot, keep-fuse and debug pins pass two flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bootSync1_q <= 1'b0;
      bootSync2_q <= 1'b0;
      keepSync1_q <= 1'b0;
      keepSync2_q <= 1'b0;
      dbgSync1_q <= 1'b0;
      dbgSync2_q <= 1'b0;
    end else begin
      bootSync1_q <= cpuInBoot;
      bootSync2_q <= bootSync1_q;
      keepSync1_q <= eepromKeepFuse;
      keepSync2_q <= keepSync1_q;
      dbgSync1_q <= dbgPortAccess;
      dbgSync2_q <= dbgSync1_q;
    end
  end

  // Bus decode; access completes one cycle after it is seen
  assign accessPend = (avs_read | avs_write) & ~ack_q;
  assign wrStb = avs_write & ack_q;
  assign idx = avs_address[5:2];
  assign wb = avs_writedata[7:0];
  assign regHit = (avs_address[1:0] == 2'b00) && (idx <= NVC_IDX_KEY) && (idx != 4'h5);
  assign busyNow = (state_q != NVC_IDLE);

  // Command acceptance: key window, busy and origin checks
  always_comb begin
    cmdIsEe = (addr_q >= EEPROM_BASE) && (addr_q <= EEPROM_END);
    cmdAccept = 1'b0;
    cmdFault = 1'b0;
    if (wrStb && avs_byteenable[0] && idx == NVC_IDX_CMD && keyCnt_q != 3'h0
        && !busyNow) begin
      cmdAccept = (wb[2:0] != NVC_CMD_FUSE) || dbgSync2_q;
      if (wb[2:0] == NVC_CMD_WRITE || wb[2:0] == NVC_CMD_ERWR || wb[2:0] == NVC_CMD_ERASE) begin
        cmdFault = pbufMixedSections
          || (appProt_q && addr_q > BOOT_END && addr_q <= APP_END);
      end
    end
  end

  // Timer length: buffer clear is short, others nominal
  assign timerLoad = cmdAccept && !cmdFault && wb[2:0] != NVC_CMD_NONE;
  assign timerCount = (wb[2:0] == NVC_CMD_BUFCLR) ? NVC_BUFCLR_CYCLES : NVC_OP_CYCLES;

  nvc_op_timer #(
    .WIDTH(8)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(timerLoad),
    .count(timerCount),
    .running(timerRunning),
    .done(timerDone)
  );

  // Key window counts down each cycle, standing in for instructions
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      keyCnt_q <= 3'h0;
    end else if (wrStb && avs_byteenable[0] && idx == NVC_IDX_KEY && wb == NVC_UNLOCK_KEY) begin
      keyCnt_q <= NVC_KEY_WINDOW;
    end else if (wrStb && idx == NVC_IDX_CMD) begin
      keyCnt_q <= 3'h0;
    end else if (keyCnt_q != 3'h0) begin
      keyCnt_q <= keyCnt_q - 3'h1;
    end
  end

  // Command register and operation engine
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= NVC_CMD_NONE;
      state_q <= NVC_IDLE;
      eeOp_q <= 1'b0;
      arrayStartPulse <= 1'b0;
      arrayCmd <= NVC_CMD_NONE;
      arrayKeepEeprom <= 1'b0;
      pbufClearPulse <= 1'b0;
    end else begin
      arrayStartPulse <= 1'b0;
      pbufClearPulse <= 1'b0;
      unique case (state_q)
        NVC_IDLE: begin
          if (timerLoad) begin
            cmd_q <= wb[2:0];
            arrayCmd <= wb[2:0];
            arrayKeepEeprom <= (wb[2:0] == NVC_CMD_FULLER) && keepSync2_q;
            arrayStartPulse <= 1'b1;
            eeOp_q <= (wb[2:0] == NVC_CMD_EEWIPE)
              || ((wb[2:0] == NVC_CMD_FULLER) && !keepSync2_q)
              || (cmdIsEe && wb[2:0] <= NVC_CMD_ERWR);
            state_q <= NVC_RUN;
          end else if (cmdAccept) begin
            cmd_q <= wb[2:0];
          end
        end
        NVC_RUN: begin
          if (timerDone) begin
            state_q <= NVC_DONE;
          end
        end
        NVC_DONE: begin
          // Buffer cleared after page operations and explicit clears
          pbufClearPulse <= (cmd_q <= NVC_CMD_BUFCLR);
          cmd_q <= NVC_CMD_NONE;
          eeOp_q <= 1'b0;
          state_q <= NVC_IDLE;
        end
      endcase
    end
  end

  // Busy flags follow the running operation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flashBusy <= 1'b0;
      eepromBusy <= 1'b0;
    end else begin
      flashBusy <= (state_q == NVC_RUN) && !eeOp_q;
      eepromBusy <= (state_q == NVC_RUN) && eeOp_q;
    end
  end

  // Write fault holds the outcome of the last attempted operation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      writeFault_q <= 1'b0;
    end else if (cmdAccept && wb[2:0] != NVC_CMD_NONE) begin
      writeFault_q <= cmdFault;
    end
  end

  // Protection bits are set-only; boot lock write allowed from boot code
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      appProt_q <= 1'b0;
      boot_read_lock_q <= 1'b0;
    end else if (wrStb && avs_byteenable[0] && idx == NVC_IDX_PROT) begin
      if (wb[NVC_BIT_APPPROT]) begin
        appProt_q <= 1'b1;
      end
      if (wb[NVC_BIT_BOOTRDLK] && bootSync2_q) begin
        boot_read_lock_q <= 1'b1;
      end
    end
  end

  // Lock arms on first exit from boot after being set
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lockArmed_q <= 1'b0;
      wasInBoot_q <= 1'b0;
    end else begin
      wasInBoot_q <= bootSync2_q;
      if (boot_read_lock_q && wasInBoot_q && !bootSync2_q) begin
        lockArmed_q <= 1'b1;
      end
    end
  end

  // Fetch path; boot data zeroed once armed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchData <= NVC_RST_WORD;
    end else if (lockArmed_q && fetchAddr <= BOOT_END) begin
      fetchData <= NVC_RST_WORD;
    end else begin
      fetchData <= fetchRawData;
    end
  end

  // Ready flag: set wins over software clear while idle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eeprom_ready_q <= 1'b0;
    end else if (!busyNow) begin
      eeprom_ready_q <= 1'b1;
    end else if (wrStb && idx == NVC_IDX_IRQFLG && wb[NVC_BIT_EERDY]) begin
      eeprom_ready_q <= 1'b0;
    end
  end

  // Interrupt enable and level request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn_q <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      if (wrStb && avs_byteenable[0] && idx == NVC_IDX_IRQEN) begin
        irqEn_q <= wb[NVC_BIT_EERDY];
      end
      irqReq <= irqEn_q && eeprom_ready_q;
    end
  end

  // Data and address words; written only by bus byte writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= NVC_RST_WORD;
      addr_q <= NVC_RST_WORD;
    end else if (wrStb && avs_byteenable[0]) begin
      unique case (idx)
        NVC_IDX_DATAL: data_q[7:0] <= wb;
        NVC_IDX_DATAH: data_q[15:8] <= wb;
        NVC_IDX_ADDRL: addr_q[7:0] <= wb;
        NVC_IDX_ADDRH: addr_q[15:8] <= wb;
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      NVC_IDX_CMD: rdata_d[2:0] = cmd_q;
      NVC_IDX_PROT: rdata_d[1:0] = {boot_read_lock_q, appProt_q};
      NVC_IDX_STATE: rdata_d[2:0] = {writeFault_q, eepromBusy, flashBusy};
      NVC_IDX_IRQEN: rdata_d[0] = irqEn_q;
      NVC_IDX_IRQFLG: rdata_d[0] = eeprom_ready_q;
      NVC_IDX_DATAL: rdata_d[7:0] = data_q[7:0];
      NVC_IDX_DATAH: rdata_d[7:0] = data_q[15:8];
      NVC_IDX_ADDRL: rdata_d[7:0] = addr_q[7:0];
      NVC_IDX_ADDRH: rdata_d[7:0] = addr_q[15:8];
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // One wait state; unmapped gives slave error response
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else begin
      ack_q <= accessPend;
      if (accessPend) begin
        avs_readdata <= (avs_read && regHit) ? rdata_d : 32'h0000_0000;
        avs_response <= regHit ? 2'b00 : 2'b10;
      end
    end
  end

  // Waitrequest held high except for the acknowledge cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~accessPend;
    end
  end
endmodule // nvc_command_controller

/* File: hw/nvc_op_timer.sv */
// Purpose: Countdown timer standing in for array operation duration
// Assumes: load pulse with nonzero count
// Notes: done pulses once when the count expires
`timescale 1ns/10ps
module nvc_op_timer #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;

  initial begin
    if (WIDTH < 2) $error("WIDTH too small");
  end

  // Countdown; done fires on the last tick
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= count;
        running <= 1'b1;
      end else if (running) begin
        if (cnt_q <= WIDTH'(1)) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - WIDTH'(1);
        end
      end
    end
  end
endmodule // nvc_op_timer

/* File: hw/nvc_pkg.sv */
// Purpose: Shared constants for the nonvolatile memory command controller
// Assumes: Byte-indexed registers, word aligned on Avalon-MM (byte addr = 4 * index)
// Notes: Register indices keep their printed values; bus address is index times four
package nvc_pkg;
  // Register indices
  localparam logic [3:0] NVC_IDX_CMD = 4'h0;
  localparam logic [3:0] NVC_IDX_PROT = 4'h1;
  localparam logic [3:0] NVC_IDX_STATE = 4'h2;
  localparam logic [3:0] NVC_IDX_IRQEN = 4'h3;
  localparam logic [3:0] NVC_IDX_IRQFLG = 4'h4;
  localparam logic [3:0] NVC_IDX_DATAL = 4'h6;
  localparam logic [3:0] NVC_IDX_DATAH = 4'h7;
  localparam logic [3:0] NVC_IDX_ADDRL = 4'h8;
  localparam logic [3:0] NVC_IDX_ADDRH = 4'h9;
  localparam logic [3:0] NVC_IDX_KEY = 4'hA;
  // Field positions
  localparam int NVC_BIT_APPPROT = 0;
  localparam int NVC_BIT_BOOTRDLK = 1;
  localparam int NVC_BIT_FLBSY = 0;
  localparam int NVC_BIT_EEBSY = 1;
  localparam int NVC_BIT_WERR = 2;
  localparam int NVC_BIT_EERDY = 0;
  // Reset values
  localparam logic [7:0] NVC_RST_BYTE = 8'h00;
  localparam logic [15:0] NVC_RST_WORD = 16'h0000;
  // Unlock key and window of four instructions
  // Unlock pattern is arbitrary; any byte unlikely to be written by accident
  localparam logic [7:0] NVC_UNLOCK_KEY = 8'hA5;
  localparam logic [2:0] NVC_KEY_WINDOW = 3'h4;
  // Commands
  localparam logic [2:0] NVC_CMD_NONE = 3'h0;
  localparam logic [2:0] NVC_CMD_WRITE = 3'h1;
  localparam logic [2:0] NVC_CMD_ERASE = 3'h2;
  localparam logic [2:0] NVC_CMD_ERWR = 3'h3;
  localparam logic [2:0] NVC_CMD_BUFCLR = 3'h4;
  localparam logic [2:0] NVC_CMD_FULLER = 3'h5;
  localparam logic [2:0] NVC_CMD_EEWIPE = 3'h6;
  localparam logic [2:0] NVC_CMD_FUSE = 3'h7;
  // Operation timing in cycles
  localparam logic [7:0] NVC_OP_CYCLES = 8'h10;
  localparam logic [7:0] NVC_BUFCLR_CYCLES = 8'h07;
  // Engine states
  typedef enum logic [2:0] {
    NVC_IDLE = 3'b001,
    NVC_RUN = 3'b010,
    NVC_DONE = 3'b100
  } nvc_state_e;
endpackage

/* File: tb/nvc_command_controller_bench.sv */
// Purpose: Register-level regression of the command controller
// Assumes: Key then command back to back fits the unlock window
// Notes: Array strobes are counted by a monitor, not modelled
`timescale 1ns/10ps
module nvc_command_controller_bench;
  import nvc_pkg::*;
  logic ref_clk, rst_b, avs_read, avs_write, dbgPortAccess, cpuInBoot, eepromKeepFuse;
  logic pbufMixedSections, avs_waitrequest, flashBusy, eepromBusy, arrayStartPulse;
  logic arrayKeepEeprom, pbufClearPulse, irqReq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, rsp;
  logic [15:0] fetchAddr, fetchRawData, fetchData;
  logic [2:0] arrayCmd, lastCmd;
  logic [7:0] rdv;
  int failures, checked, starts, clears, c0, i;
  nvc_command_controller i_dut (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .dbgPortAccess, .cpuInBoot, .eepromKeepFuse, .pbufMixedSections, .fetchAddr,
    .fetchRawData, .fetchData, .flashBusy, .eepromBusy, .arrayStartPulse, .arrayCmd,
    .arrayKeepEeprom, .pbufClearPulse, .irqReq);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Strobe monitor; pulses stand one cycle only
  always @(posedge ref_clk) begin
    if (arrayStartPulse === 1'b1) begin
      starts++;
      lastCmd = arrayCmd;
    end
    if (pbufClearPulse === 1'b1) clears++;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, wd};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rdv = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdChk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, 16'(rdv), 16'(exp));
  endtask
  // Unlock then launch; a refused launch gives no start strobe
  task automatic issue(input logic [2:0] code, input int expStart);
    int s0;
    s0 = starts;
    bus(1'b1, NVC_IDX_KEY, NVC_UNLOCK_KEY);
    bus(1'b1, NVC_IDX_CMD, {5'h00, code});
    repeat (3) @(posedge ref_clk);
    check("start count", 16'(starts - s0), 16'(expStart));
    if (expStart != 0) check("array command", 16'(lastCmd), 16'(code));
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    while ((flashBusy | eepromBusy) !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    final_report;
  end
  initial begin
    {rst_b, avs_read, avs_write, dbgPortAccess, cpuInBoot, eepromKeepFuse} = 6'h00;
    {pbufMixedSections, avs_address, avs_writedata} = 39'h0;
    avs_byteenable = 4'hF;
    fetchAddr = 16'h0010;
    fetchRawData = 16'hABCD;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 10; i++) begin
      if (i != 5) rdChk("reset value", 4'(i), (i == 4) ? 8'h01 : 8'h00);
    end
    for (i = 6; i < 10; i++) begin
      bus(1'b1, 4'(i), 8'(8'hA0 + i));
      rdChk("data or address byte", 4'(i), 8'(8'hA0 + i));
    end
    rdChk("hole read", 4'h5, 8'h00);
    check("hole response", 16'(rsp), 16'h0002);
    $display("test registers done");
    bus(1'b1, NVC_IDX_ADDRL, 8'h00);
    bus(1'b1, NVC_IDX_ADDRH, 8'h00);
    bus(1'b1, NVC_IDX_CMD, 8'h01);
    rdChk("unkeyed command", NVC_IDX_CMD, 8'h00);
    for (i = 0; i < 7; i++) begin
      c0 = clears;
      issue(3'(i), (i != 0) ? 1 : 0);
      if (i != 0) rdChk("busy flags", NVC_IDX_STATE, (i >= 5) ? 8'h02 : 8'h01);
      waitIdle;
      check("buffer clears", 16'(clears - c0), (i >= 1 && i <= 4) ? 16'h1 : 16'h0);
    end
    issue(NVC_CMD_FUSE, 0);
    dbgPortAccess <= 1'b1;
    repeat (3) @(posedge ref_clk);
    issue(NVC_CMD_FUSE, 1);
    waitIdle;
    dbgPortAccess <= 1'b0;
    issue(NVC_CMD_ERASE, 1);
    issue(NVC_CMD_EEWIPE, 0);
    waitIdle;
    $display("test commands done");
    pbufMixedSections <= 1'b1;
    issue(NVC_CMD_WRITE, 0);
    rdChk("fault flag", NVC_IDX_STATE, 8'h04);
    pbufMixedSections <= 1'b0;
    issue(NVC_CMD_ERASE, 1);
    rdChk("fault cleared", NVC_IDX_STATE, 8'h01);
    waitIdle;
    eepromKeepFuse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    issue(NVC_CMD_FULLER, 1);
    check("keep eeprom", 16'(arrayKeepEeprom), 16'h0001);
    rdChk("flash only busy", NVC_IDX_STATE, 8'h01);
    waitIdle;
    bus(1'b1, NVC_IDX_PROT, 8'h01);
    bus(1'b1, NVC_IDX_PROT, 8'h00);
    rdChk("app protect", NVC_IDX_PROT, 8'h01);
    bus(1'b1, NVC_IDX_ADDRH, 8'h02);
    issue(NVC_CMD_WRITE, 0);
    rdChk("protect fault", NVC_IDX_STATE, 8'h04);
    $display("test protection done");
    bus(1'b1, NVC_IDX_PROT, 8'h02);
    rdChk("boot lock outside", NVC_IDX_PROT, 8'h01);
    cpuInBoot <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b1, NVC_IDX_PROT, 8'h02);
    rdChk("boot lock", NVC_IDX_PROT, 8'h03);
    check("fetch before exit", fetchData, 16'hABCD);
    cpuInBoot <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("locked fetch", fetchData, 16'h0000);
    fetchAddr <= 16'h0300;
    repeat (2) @(posedge ref_clk);
    check("app fetch", fetchData, 16'hABCD);
    $display("test boot lock done");
    bus(1'b1, NVC_IDX_IRQEN, 8'h01);
    repeat (2) @(posedge ref_clk);
    check("irq idle", 16'(irqReq), 16'h0001);
    issue(NVC_CMD_EEWIPE, 1);
    bus(1'b1, NVC_IDX_IRQFLG, 8'h01);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", 16'(irqReq), 16'h0000);
    waitIdle;
    check("irq ready", 16'(irqReq), 16'h0001);
    bus(1'b1, NVC_IDX_IRQEN, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq masked", 16'(irqReq), 16'h0000);
    $display("test interrupt done");
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdChk("protect after reset", NVC_IDX_PROT, 8'h00);
    $display("test second reset done");
    final_report;
  end
endmodule // nvc_command_controller_bench

/* File: tb/nvc_command_controller_props.sv */
// Purpose: Port checks for the command controller
// Assumes: Master drops its request for a cycle after each answer
// Notes: Attached to every controller instance
`timescale 1ns/10ps
module nvc_command_controller_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [15:0] fetchRawData,
  input wire logic [15:0] fetchData,
  input wire logic flashBusy,
  input wire logic eepromBusy,
  input wire logic arrayStartPulse,
  input wire logic pbufClearPulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] busyCnt_q;
  // Busy spell length; saturates so a stuck flag still fails
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt_q <= 8'h00;
    end else if (!(flashBusy | eepromBusy)) begin
      busyCnt_q <= 8'h00;
    end else if (busyCnt_q != 8'hFF) begin
      busyCnt_q <= busyCnt_q + 8'h01;
    end
  end
  // Bus handshake and register map
  wait_one_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not one cycle after request");
  wait_drop_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  unmapped_resp_a: assert property (!avs_waitrequest && avs_address[5:2] == 4'h5 |->
    avs_response == 2'b10 && avs_readdata == 32'h0) else $error("hole not refused");
  byte_read_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Commands and array activity
  start_cause_a: assert property (arrayStartPulse |-> $past(avs_write & ~avs_waitrequest)
    && $past(avs_address) == 6'h00 && !$past(flashBusy | eepromBusy)) else $error("stray start");
  busy_follow_a: assert property (arrayStartPulse |=> !arrayStartPulse ##[0:1] (flashBusy | eepromBusy))
    else $error("no busy after start");
  op_length_a: assert property ((flashBusy | eepromBusy) |-> busyCnt_q < 8'h14)
    else $error("operation too long");
  clear_end_a: assert property (pbufClearPulse |-> ##[0:1] !(flashBusy | eepromBusy))
    else $error("buffer clear not at end");
  fetch_pass_a: assert property (fetchData != 16'h0000 |-> fetchData == $past(fetchRawData))
    else $error("fetch data altered");
  cover property (arrayStartPulse);
  cover property (pbufClearPulse);
  cover property ($fell(eepromBusy));
endmodule // nvc_command_controller_props

bind nvc_command_controller nvc_command_controller_props i_props (.ref_clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .fetchRawData,
  .fetchData, .flashBusy, .eepromBusy, .arrayStartPulse, .pbufClearPulse);
